// *** pdcm_pkg.sv ***
package pdcm_pkg;

  // ------------------------------------------------------------
  // widths and pin positions
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int AUX_W  = 10;
  localparam int BIT_TXD = 0;
  localparam int BIT_RXD = 1;
  localparam int BIT_RTS = 2;
  localparam int BIT_CTS = 3;
  localparam int BIT_DTR = 4;
  localparam int BIT_DSR = 5;
  localparam int BIT_DCD = 6;
  localparam int BIT_RI  = 7;
  localparam int AUX_PD_PIN = 7;

  // ------------------------------------------------------------
  // timing: memory clock divider (half period in cycles)
  // ------------------------------------------------------------
  localparam int CLK_MHZ      = 125;
  localparam int MEM_CLK_KHZ  = 1000;
  localparam int MEM_HALF_CYC = (CLK_MHZ * 1000) / (2 * MEM_CLK_KHZ);

  // ------------------------------------------------------------
  // auxiliary pin function codes
  // ------------------------------------------------------------
  localparam logic [3:0] AUX_FN_PULLUP   = 4'h0;
  localparam logic [3:0] AUX_FN_PULLDOWN = 4'h1;
  localparam logic [3:0] AUX_FN_DRIVE0   = 4'h2;
  localparam logic [3:0] AUX_FN_DRIVE1   = 4'h3;
  localparam logic [3:0] AUX_FN_POWER_ENABLE_N    = 4'h4;
  localparam logic [3:0] AUX_FN_SLEEP    = 4'h5;

  // ------------------------------------------------------------
  // stored configuration layout (one word per aux pin + option word)
  // ------------------------------------------------------------
  localparam int CFG_WORDS   = AUX_W + 1;
  localparam int OPT_WAKE    = 0;
  localparam int OPT_SUSP_PD = 1;
  localparam logic [15:0] CFG_SIGNATURE = 16'h5aa5;

  typedef enum logic [1:0] {PDCM_ST_RESET, PDCM_ST_LOAD, PDCM_ST_RUN} pdcm_state_t;

  // modem signals as seen by the serial engine
  typedef struct packed {
    logic txd;
    logic rts_n;
    logic dtr_n;
  } pdcm_modem_out_t;

  typedef struct packed {
    logic rxd;
    logic cts_n;
    logic dsr_n;
    logic dcd_n;
    logic ri_n;
  } pdcm_modem_in_t;

  // one pin: output, output enable, weak pull up, weak pull down
  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
    logic pd;
  } pdcm_pin_t;

endpackage

// *** pdcm_pin_default_config_mux.sv ***
`timescale 1ns/1ps
// Overview of operation
// - while reset is held, memory select, clock and data are not driven.
// - after reset release the memory clock pin carries the memory access clock.
// - by default data bit 0 is serial transmit out and bit 1 serial receive in.
// - by default bits 2 and 4 are rts and dtr outputs, bits 3 and 5 cts and dsr inputs.
// - by default bit 6 is carrier detect and bit 7 ring indicator, both modem status inputs.
// - with wakeup enabled and suspended, ring indicator low requests a resume to the host.
// - each aux pin takes its stored function, or weak pull-up input with no memory fitted, except pin 7.
// - aux pin 7 defaults to weak pull-down input with no memory fitted.
// - input pins pull high, or gently low in suspend when the stored option is set.
// - power enable goes low once configured and high again in suspend.
module pdcm_pin_default_config_mux #(
  parameter int HALF_CYC = pdcm_pkg::MEM_HALF_CYC
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        clk_en,
  // configuration memory pins
  output logic                             cfgmem_select,
  output logic                             cfgmem_select_oe,
  output logic                             cfgmem_clock,
  output logic                             cfgmem_clock_oe,
  input  wire logic                        cfgmem_data_i,
  output logic                             cfgmem_data_o,
  output logic                             cfgmem_data_oe,
  // configuration memory word port from the serial memory engine
  input  wire logic                        cfg_word_valid,
  input  wire logic [15:0]                 cfg_word,
  input  wire logic                        cfg_done,
  input  wire logic                        cfg_absent,
  output logic                             cfg_load_req,
  output logic                             cfg_bit_in,
  // serial engine side
  input  wire pdcm_pkg::pdcm_modem_out_t   modem_out,
  output pdcm_pkg::pdcm_modem_in_t         modem_in,
  input  wire logic                        mem_sel_req,
  input  wire logic                        mem_data_out,
  input  wire logic                        mem_data_drive,
  // usb state
  input  wire logic                        usb_configured,
  input  wire logic                        usb_suspended,
  output logic                             resume_req,
  output logic                             power_enable_n,
  output logic                             cfg_loaded,
  // primary data bus pins
  input  wire logic [pdcm_pkg::DATA_W-1:0] primary_data_bus_i,
  output logic [pdcm_pkg::DATA_W-1:0]      primary_data_bus_o,
  output logic [pdcm_pkg::DATA_W-1:0]      primary_data_bus_oe,
  output logic [pdcm_pkg::DATA_W-1:0]      primary_data_bus_pu,
  output logic [pdcm_pkg::DATA_W-1:0]      primary_data_bus_pd,
  // auxiliary bus pins
  input  wire logic [pdcm_pkg::AUX_W-1:0]  auxiliary_bus_i,
  output logic [pdcm_pkg::AUX_W-1:0]       auxiliary_bus_o,
  output logic [pdcm_pkg::AUX_W-1:0]       auxiliary_bus_oe,
  output logic [pdcm_pkg::AUX_W-1:0]       auxiliary_bus_pu,
  output logic [pdcm_pkg::AUX_W-1:0]       auxiliary_bus_pd
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [pdcm_pkg::DATA_W-1:0] pd_s1;
  logic [pdcm_pkg::DATA_W-1:0] pd_s2;
  logic                        md_s1;
  logic                        md_s2;

  // two stages; only the second stage is read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_s1 <= '1;
      pd_s2 <= '1;
      md_s1 <= 1'b1;
      md_s2 <= 1'b1;
    end else if (clk_en) begin
      pd_s1 <= primary_data_bus_i;
      pd_s2 <= pd_s1;
      md_s1 <= cfgmem_data_i;
      md_s2 <= md_s1;
    end
  end

  assign cfg_bit_in = md_s2;

  // ----------------------------------------------------------------
  // configuration load sequencing
  // ----------------------------------------------------------------
  pdcm_pkg::pdcm_state_t state;
  pdcm_pkg::pdcm_state_t next_state;
  logic [3:0]            aux_fn [pdcm_pkg::AUX_W];
  logic [15:0]           options;
  logic                  mem_valid;
  logic [3:0]            word_idx;
  logic                  sig_ok;
  logic                  cfg_word_take;

  assign sig_ok        = (cfg_word == pdcm_pkg::CFG_SIGNATURE);
  assign cfg_word_take = (state == pdcm_pkg::PDCM_ST_LOAD) && cfg_word_valid;

  // leave reset, load, then run; absence falls back to defaults
  always_comb begin
    next_state = state;
    case (state)
      pdcm_pkg::PDCM_ST_RESET: next_state = pdcm_pkg::PDCM_ST_LOAD;
      pdcm_pkg::PDCM_ST_LOAD: begin
        if (cfg_done || cfg_absent) begin
          next_state = pdcm_pkg::PDCM_ST_RUN;
        end
      end
      default: next_state = pdcm_pkg::PDCM_ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= pdcm_pkg::PDCM_ST_RESET;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // word 0 is the signature, then options, then one word per aux pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_idx  <= 4'h0;
      mem_valid <= 1'b0;
      options   <= 16'h0000;
    end else if (clk_en) begin
      if (cfg_word_take) begin
        word_idx <= word_idx + 4'h1;
        if (word_idx == 4'h0) begin
          mem_valid <= sig_ok;
        end else if (word_idx == 4'h1) begin
          options <= cfg_word;
        end
      end
      if (state == pdcm_pkg::PDCM_ST_LOAD && cfg_absent) begin
        mem_valid <= 1'b0;
      end
    end
  end

  // per-pin function store
  for (genvar g = 0; g < pdcm_pkg::AUX_W; g++) begin : g_fn
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        aux_fn[g] <= pdcm_pkg::AUX_FN_PULLUP;
      end else if (clk_en && cfg_word_take && word_idx == 4'(g + 2)) begin
        aux_fn[g] <= cfg_word[3:0];
      end
    end
  end

  assign cfg_load_req = (state == pdcm_pkg::PDCM_ST_LOAD);
  assign cfg_loaded   = (state == pdcm_pkg::PDCM_ST_RUN);

  // ----------------------------------------------------------------
  // memory clock divider and memory pins
  // ----------------------------------------------------------------
  logic [7:0] div_cnt;
  logic       mem_clk;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 8'h00;
      mem_clk <= 1'b0;
    end else if (clk_en) begin
      if (div_cnt == 8'(HALF_CYC - 1)) begin
        div_cnt <= 8'h00;
        mem_clk <= ~mem_clk;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // reset drops the enables asynchronously, so pins float in reset
  assign cfgmem_clock     = mem_clk;
  assign cfgmem_clock_oe  = (state != pdcm_pkg::PDCM_ST_RESET);
  assign cfgmem_select    = mem_sel_req & cfgmem_clock_oe;
  assign cfgmem_select_oe = cfgmem_clock_oe;
  assign cfgmem_data_o    = mem_data_out;
  assign cfgmem_data_oe   = cfgmem_clock_oe & mem_data_drive;

  // ----------------------------------------------------------------
  // suspend pull policy and usb status outputs
  // ----------------------------------------------------------------
  logic susp_pd;
  logic wake_en;

  assign susp_pd = mem_valid & options[pdcm_pkg::OPT_SUSP_PD] & usb_suspended;
  assign wake_en = mem_valid & options[pdcm_pkg::OPT_WAKE];

  // resume is a level held while suspended and ring indicator stays low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resume_req     <= 1'b0;
      power_enable_n <= 1'b1;
    end else if (clk_en) begin
      resume_req     <= wake_en & usb_suspended & ~pd_s2[pdcm_pkg::BIT_RI];
      power_enable_n <= ~(usb_configured & ~usb_suspended);
    end
  end

  // ----------------------------------------------------------------
  // primary data bus: fixed default serial and modem assignment
  // ----------------------------------------------------------------
  localparam logic [pdcm_pkg::DATA_W-1:0] PRIM_OUT_MASK = 8'h15;

  always_comb begin
    primary_data_bus_o                    = '0;
    primary_data_bus_o[pdcm_pkg::BIT_TXD] = modem_out.txd;
    primary_data_bus_o[pdcm_pkg::BIT_RTS] = modem_out.rts_n;
    primary_data_bus_o[pdcm_pkg::BIT_DTR] = modem_out.dtr_n;
  end

  assign primary_data_bus_oe = cfg_loaded ? PRIM_OUT_MASK : '0;
  assign primary_data_bus_pu = ~primary_data_bus_oe & {pdcm_pkg::DATA_W{~susp_pd}};
  assign primary_data_bus_pd = ~primary_data_bus_oe & {pdcm_pkg::DATA_W{susp_pd}};

  assign modem_in.rxd   = pd_s2[pdcm_pkg::BIT_RXD];
  assign modem_in.cts_n = pd_s2[pdcm_pkg::BIT_CTS];
  assign modem_in.dsr_n = pd_s2[pdcm_pkg::BIT_DSR];
  assign modem_in.dcd_n = pd_s2[pdcm_pkg::BIT_DCD];
  assign modem_in.ri_n  = pd_s2[pdcm_pkg::BIT_RI];

  // ----------------------------------------------------------------
  // auxiliary bus: stored function, or defaults when no memory
  // ----------------------------------------------------------------
  function automatic pdcm_pkg::pdcm_pin_t aux_decode(input logic [3:0] fn, input logic pwr_n,
                                                     input logic susp, input logic spd);
    pdcm_pkg::pdcm_pin_t p;
    p = '{o: 1'b0, oe: 1'b0, pu: ~spd, pd: spd};
    if (fn == pdcm_pkg::AUX_FN_PULLDOWN) begin
      p = '{o: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b1};
    end else if (fn == pdcm_pkg::AUX_FN_DRIVE0) begin
      p = '{o: 1'b0, oe: 1'b1, pu: 1'b0, pd: 1'b0};
    end else if (fn == pdcm_pkg::AUX_FN_DRIVE1) begin
      p = '{o: 1'b1, oe: 1'b1, pu: 1'b0, pd: 1'b0};
    end else if (fn == pdcm_pkg::AUX_FN_POWER_ENABLE_N) begin
      p = '{o: pwr_n, oe: 1'b1, pu: 1'b0, pd: 1'b0};
    end else if (fn == pdcm_pkg::AUX_FN_SLEEP) begin
      p = '{o: ~susp, oe: 1'b1, pu: 1'b0, pd: 1'b0};
    end
    return p;
  endfunction

  for (genvar g = 0; g < pdcm_pkg::AUX_W; g++) begin : g_aux
    logic [3:0]          fn_eff;
    pdcm_pkg::pdcm_pin_t pin;
    // until loaded, or with no valid memory, defaults apply
    assign fn_eff = (cfg_loaded && mem_valid) ? aux_fn[g] :
                    (g == pdcm_pkg::AUX_PD_PIN) ? pdcm_pkg::AUX_FN_PULLDOWN :
                    pdcm_pkg::AUX_FN_PULLUP;
    assign pin = aux_decode(fn_eff, power_enable_n, usb_suspended, susp_pd);
    assign auxiliary_bus_o[g]  = pin.o;
    assign auxiliary_bus_oe[g] = pin.oe;
    assign auxiliary_bus_pu[g] = pin.pu;
    assign auxiliary_bus_pd[g] = pin.pd;
  end

endmodule

// *** pdcm_properties.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// pin default checker
// ------------------------------------------------------------
module pdcm_properties #(
  parameter int HALF_CYC = pdcm_pkg::MEM_HALF_CYC
) (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic                        clk_en,
  // memory pins
  input wire logic                        cfgmem_select_oe,
  input wire logic                        cfgmem_clock,
  input wire logic                        cfgmem_clock_oe,
  input wire logic                        cfgmem_data_oe,
  // serial engine and usb state
  input wire pdcm_pkg::pdcm_modem_out_t   modem_out,
  input wire pdcm_pkg::pdcm_modem_in_t    modem_in,
  input wire logic                        usb_suspended,
  input wire logic                        resume_req,
  input wire logic                        cfg_loaded,
  // pins
  input wire logic [pdcm_pkg::DATA_W-1:0] primary_data_bus_i,
  input wire logic [pdcm_pkg::DATA_W-1:0] primary_data_bus_o,
  input wire logic [pdcm_pkg::DATA_W-1:0] primary_data_bus_oe,
  input wire logic [pdcm_pkg::AUX_W-1:0]  auxiliary_bus_pu,
  input wire logic [pdcm_pkg::AUX_W-1:0]  auxiliary_bus_pd
);
  localparam int GAP = HALF_CYC + 1;
  logic [pdcm_pkg::DATA_W-1:0] pin_q1;
  logic [pdcm_pkg::DATA_W-1:0] pin_q2;
  // pin history, same depth and enable as the input synchroniser
  always_ff @(posedge clk) begin
    if (clk_en) begin
      pin_q1 <= primary_data_bus_i;
      pin_q2 <= pin_q1;
    end
  end
  default clocking @(posedge clk); endclocking
  // a frozen block makes no progress, so timing checks pause with it
  default disable iff (!rst_b || !clk_en);
  // reset checks must stay live while reset is held
  a_mem_float: assert property (disable iff (1'b0)
    !rst_b |-> !(cfgmem_select_oe | cfgmem_clock_oe | cfgmem_data_oe)) else $error("mem pin driven");
  a_clk_runs: assert property (
    cfgmem_clock_oe |-> ##[1:GAP] $changed(cfgmem_clock)) else $error("memory clock stuck");
  a_tx_route: assert property (
    cfg_loaded |-> primary_data_bus_o[0] == modem_out.txd && primary_data_bus_oe[1:0] == 2'b01)
    else $error("tx or rx pin wrong");
  a_hs_route: assert property (
    cfg_loaded |-> {primary_data_bus_o[2], primary_data_bus_o[4]} == {modem_out.rts_n,
    modem_out.dtr_n} && primary_data_bus_oe[5:2] == 4'h5) else $error("handshake pin wrong");
  a_status_sync: assert property (
    cfg_loaded |-> modem_in == {pin_q2[1], pin_q2[3], pin_q2[5], pin_q2[6], pin_q2[7]})
    else $error("modem status wrong");
  a_ring_wake: assert property (
    $rose(resume_req) |-> $past(usb_suspended) && !$past(pin_q2[7]))
    else $error("resume without cause");
  a_aux_pullup: assert property (disable iff (1'b0)
    !rst_b |-> auxiliary_bus_pu == 10'h37f) else $error("aux pull-up wrong in reset");
  a_aux7_pulldown: assert property (disable iff (1'b0)
    !rst_b |-> auxiliary_bus_pd == 10'h080) else $error("aux pull-down wrong in reset");
endmodule

// *** pdcm_cfg_partner.sv ***
`timescale 1ns/1ps
// config memory model: serves twelve stored words
module pdcm_cfg_partner (
  // bench controls
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         present,
  input  wire logic         slow,
  input  wire logic [191:0] image,
  // word port
  input  wire logic         cfg_load_req,
  output logic              cfg_word_valid,
  output logic [15:0]       cfg_word,
  output logic              cfg_done,
  output logic              cfg_absent
);
  int   idx;
  logic ph;
  // a word per cycle, or every other one when slow; stale word keeps flipping
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx            <= 0;
      ph             <= 1'b0;
      cfg_word_valid <= 1'b0;
      cfg_word       <= 16'h0000;
      cfg_done       <= 1'b0;
      cfg_absent     <= 1'b0;
    end else begin
      ph             <= ~ph;
      cfg_word_valid <= 1'b0;
      cfg_done       <= 1'b0;
      cfg_word       <= ~cfg_word;
      if (cfg_load_req && !present) begin
        cfg_absent <= 1'b1;
      end else if (cfg_load_req && idx < 12 && (ph || !slow)) begin
        cfg_word_valid <= 1'b1;
        cfg_word       <= image[16*idx +: 16];
        idx            <= idx + 1;
      end else if (cfg_load_req && idx == 12) begin
        cfg_done <= 1'b1;
        idx      <= 13;
      end
    end
  end
endmodule

// *** pin_default_config_mux_bench.sv ***
`timescale 1ns/1ps
module pin_default_config_mux_bench;
  localparam int HALF = 2;
  logic clk, rst_b, clk_en, cfg_word_valid, cfg_done, cfg_absent, cfg_load_req, cfg_bit_in;
  logic cfgmem_select, cfgmem_select_oe, cfgmem_clock, cfgmem_clock_oe, cfgmem_data_i;
  logic cfgmem_data_o, cfgmem_data_oe, mem_sel_req, mem_data_out, mem_data_drive, present;
  logic usb_configured, usb_suspended, resume_req, power_enable_n, cfg_loaded, slow;
  logic [15:0] cfg_word;
  logic [191:0] image;
  logic [7:0] primary_data_bus_i, primary_data_bus_o, primary_data_bus_oe, e;
  logic [7:0] primary_data_bus_pu, primary_data_bus_pd, q[$];
  logic [9:0] auxiliary_bus_i, auxiliary_bus_o, auxiliary_bus_oe, auxiliary_bus_pu;
  logic [9:0] auxiliary_bus_pd, e_oe, e_o, e_pu, e_pd;
  pdcm_pkg::pdcm_modem_out_t modem_out;
  pdcm_pkg::pdcm_modem_in_t modem_in;
  integer seed, n_fail, cmp_count, n;
  logic mq[$];
  assign cfgmem_data_i = cfgmem_data_oe ? cfgmem_data_o : 1'b1; // board pull-up
  pdcm_pin_default_config_mux #(.HALF_CYC(HALF)) dut_u (.*);
  pdcm_cfg_partner mem_u (.*);
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (exp !== got) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // reset, then a bounded wait for the load to finish
  task automatic reboot(input logic pres);
    rst_b = 1'b0;
    present = pres;
    repeat (20) @(negedge clk);
    check("mem oe", 0, {cfgmem_select_oe, cfgmem_clock_oe, cfgmem_data_oe});
    rst_b = 1'b1;
    repeat (200) if (cfg_loaded !== 1'b1) @(negedge clk);
    if (cfg_loaded !== 1'b1) begin
      check("loaded", 1, cfg_loaded);
      tally_and_finish();
    end
    @(negedge clk);
  endtask
  // stimulus changes on falling edges only
  initial begin
    seed = 43059;
    n_fail = 0;
    cmp_count = 0;
    {rst_b, slow, present, modem_out, image, auxiliary_bus_i} = '0;
    {mem_sel_req, mem_data_out, mem_data_drive, usb_configured, usb_suspended} = '0;
    clk_en = 1'b1;
    primary_data_bus_i = 8'hff;
    reboot(0);
    check("aux pu", 10'h37f, auxiliary_bus_pu);
    check("aux pd", 10'h080, auxiliary_bus_pd);
    check("aux oe", 0, auxiliary_bus_oe);
    $display("test defaults done");
    q = {8'hff, 8'hff};
    mq = {1'b1, 1'b1};
    repeat (40) begin
      @(negedge clk);
      e = q[$-1];
      check("modem in", {e[1], e[3], e[5], e[6], e[7]}, modem_in);
      check("tx rts dtr", modem_out, {primary_data_bus_o[0], primary_data_bus_o[2],
        primary_data_bus_o[4]});
      check("bus oe", 8'h15, primary_data_bus_oe);
      check("mem pins", {mem_sel_req, mem_data_out, mem_data_drive},
        {cfgmem_select, cfgmem_data_o, cfgmem_data_oe});
      check("mem bit in", mq[$-1], cfg_bit_in);
      modem_out = 3'($random(seed));
      {mem_sel_req, mem_data_out, mem_data_drive} = 3'($random(seed));
      mq.push_back(mem_data_drive ? mem_data_out : 1'b1); // board pull-up when released
      primary_data_bus_i = 8'($random(seed));
      q.push_back(primary_data_bus_i);
    end
    $display("test routing done");
    // clock enable low: divider and pin sampling must hold still
    clk_en = 1'b0;
    n = {cfgmem_clock, modem_in};
    primary_data_bus_i = ~primary_data_bus_i;
    repeat (6) @(negedge clk);
    check("frozen", n, {cfgmem_clock, modem_in});
    clk_en = 1'b1;
    $display("test freeze done");
    usb_configured = 1'b1;
    primary_data_bus_i = 8'h7f;
    @(negedge clk);
    check("power_enable_n on", 0, power_enable_n);
    usb_suspended = 1'b1;
    repeat (6) @(negedge clk);
    check("power_enable_n susp", 1, power_enable_n);
    check("no wake", 0, resume_req);
    $display("test power done");
    // pass 0 has a bad signature, pass 1 a good image served slowly
    for (int k = 0; k < 2; k++) begin
      {usb_configured, usb_suspended} = 2'b10;
      primary_data_bus_i = 8'hff;
      image[31:0] = {16'h0003, k ? pdcm_pkg::CFG_SIGNATURE : ~pdcm_pkg::CFG_SIGNATURE};
      for (int i = 0; i < 10; i++) image[32+16*i +: 16] = 16'(i % 6);
      slow = k[0];
      reboot(1);
      for (int i = 0; i < 10; i++) begin
        e_oe[i] = k && i % 6 >= 2;
        e_o[i] = k && (i % 6 == 3 || i % 6 == 5);
        e_pu[i] = k ? i % 6 == 0 : i != 7;
        e_pd[i] = k ? i % 6 == 1 : i == 7;
      end
      check("aux oe", e_oe, auxiliary_bus_oe);
      check("aux o", e_o, auxiliary_bus_o & e_oe);
      check("aux pu", e_pu, auxiliary_bus_pu & ~e_oe);
      check("aux pd", e_pd, auxiliary_bus_pd & ~e_oe);
      n = 0;
      repeat (16) begin
        e[0] = cfgmem_clock;
        @(negedge clk);
        n += (cfgmem_clock !== e[0]);
      end
      check("mem clock edges", 16 / HALF, n);
      usb_suspended = 1'b1;
      @(negedge clk);
      check("susp pulls", k ? 16'h00ea : 16'hea00,
        {primary_data_bus_pu & 8'hea, primary_data_bus_pd & 8'hea});
      check("susp aux", e_oe[5:4] & 2'b01, auxiliary_bus_o[5:4] & e_oe[5:4]);
      primary_data_bus_i = 8'h7f;
      repeat (4) @(negedge clk);
      check("wake", k, resume_req);
      $display("test load pass %0d done", k);
    end
    tally_and_finish();
  end
endmodule
bind pdcm_pin_default_config_mux pdcm_properties #(.HALF_CYC(HALF_CYC)) chk_u (
  .clk                 (clk),
  .rst_b               (rst_b),
  .clk_en              (clk_en),
  .cfgmem_select_oe    (cfgmem_select_oe),
  .cfgmem_clock        (cfgmem_clock),
  .cfgmem_clock_oe     (cfgmem_clock_oe),
  .cfgmem_data_oe      (cfgmem_data_oe),
  .modem_out           (modem_out),
  .modem_in            (modem_in),
  .usb_suspended       (usb_suspended),
  .resume_req          (resume_req),
  .cfg_loaded          (cfg_loaded),
  .primary_data_bus_i  (primary_data_bus_i),
  .primary_data_bus_o  (primary_data_bus_o),
  .primary_data_bus_oe (primary_data_bus_oe),
  .auxiliary_bus_pu    (auxiliary_bus_pu),
  .auxiliary_bus_pd    (auxiliary_bus_pd)
);
